// *** ebt_defs.vh ***
// Purpose: constants for the eight-bit compare timer
// Assumes: apb slave, 32-bit data, word-aligned registers
// Notes:   offsets are byte addresses
//
// Overview of operation
// - clear select 01 clears on match A
// - output select 0110: A sets, B clears
// - pulses repeat with no software action
// - clear beats simultaneous counter write
// - counter write beats simultaneous increment
// - compare write suppresses that cycle's match
// - simultaneous matches: toggle, one, zero, none
// - count on falling edge of divided clock
// - stopping from high source gives increment
// - internal/external switch may add one increment
// - select pairs: keep, zero, one, invert
// - match fires in last cycle before advance
// - wrap flag set on ff to 00
// - clear select 11 clears on reset rise
`ifndef EBT_DEFS_VH
`define EBT_DEFS_VH
`define EBT_OFF_CTRL    12'h000
`define EBT_OFF_STAT    12'h004
`define EBT_OFF_COUNT   12'h008
`define EBT_OFF_CMPA    12'h00c
`define EBT_OFF_CMPB    12'h010
`define EBT_OFF_IMASK   12'h014
// control register fields
`define EBT_CKS_LSB     0
`define EBT_CKS_MSB     2
`define EBT_EDG_LSB     3
`define EBT_EDG_MSB     4
`define EBT_CLR_LSB     5
`define EBT_CLR_MSB     6
`define EBT_OS_LSB      8
`define EBT_OS_MSB      11
// status bits
`define EBT_ST_WRAP     0
`define EBT_ST_MA       1
`define EBT_ST_MB       2
`define EBT_CTRL_RST    12'h000
`define EBT_CNT_RST     8'h00
`define EBT_CMP_RST     8'hff
// clear select codes
`define EBT_CLR_NONE    2'b00
`define EBT_CLR_A       2'b01
`define EBT_CLR_B       2'b10
`define EBT_CLR_EXT     2'b11
// output select pair codes
`define EBT_OS_KEEP     2'b00
`define EBT_OS_ZERO     2'b01
`define EBT_OS_ONE      2'b10
`define EBT_OS_INV      2'b11
`endif

// *** ebt_sync.v ***
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input asynchronous to pclk
// Notes:   first flop read only by the second
`timescale 1ns/1ps
module ebt_sync
(
  input  wire pclk,
  input  wire presetn,
  input  wire din,
  output wire dout
);
  reg meta_q;
  reg sync_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule // ebt_sync

// *** ebt_prescale.v ***
// Purpose: free-running divider giving the internal clock taps
// Assumes: one system clock
// Notes:   tap n is bit n of the divider, period 2^(n+1) cycles
`timescale 1ns/1ps
module ebt_prescale
#(
  parameter W = 12
)
(
  input  wire         pclk,
  input  wire         presetn,
  output wire [W-1:0] taps
);
  reg [W-1:0] div_q;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= {W{1'b0}};
    else
      div_q <= div_q + {{(W-1){1'b0}}, 1'b1};
  end

  assign taps = div_q;
endmodule // ebt_prescale

// *** ebt_timer.v ***
// Purpose: eight-bit up timer, two compare constants, one output pin
// Assumes: apb slave on pclk; external pins are asynchronous
// Notes:   clock select 0 stops the count; 1..5 internal taps; 6,7 external
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "ebt_defs.vh"
module ebt_timer
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        external_count_input,
  input  wire        ext_reset_in,
  output wire        timer_output_pin,
  output wire        irq
);
  wire        wr_en;
  wire [11:0] taps;
  wire        ext_clk_s;
  wire        ext_rst_s;
  reg  [11:0] timer_control_q;
  reg  [7:0]  count_value_q;
  reg  [7:0]  compare_const_a_q;
  reg  [7:0]  compare_const_b_q;
  reg  [2:0]  timer_ctl_status_q;
  reg  [2:0]  irq_mask_q;
  reg         out_q;
  reg         src_lvl_q;
  reg         ext_prev_q;
  reg         rst_prev_q;
  reg  [2:0]  sel_prev_q;
  reg         src_lvl_d;
  reg         ext_edge;
  wire [2:0]  clock_select_field;
  wire [1:0]  ext_edge_sel;
  wire [1:0]  clr_sel;
  wire [3:0]  output_select_bits;
  wire        inc_pulse;
  wire        sel_chg;
  wire        wr_ctrl;
  wire        wr_count;
  wire        wr_cmpa;
  wire        wr_cmpb;
  wire        match_a;
  wire        match_b;
  wire        clear_ev;
  wire        wrap_ev;
  wire [2:0]  events;

  ebt_prescale #(.W(12)) u_pre
  (
    .pclk    (pclk),
    .presetn (presetn),
    .taps    (taps)
  );

  ebt_sync u_sync_clk
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (external_count_input),
    .dout    (ext_clk_s)
  );

  ebt_sync u_sync_rst
  (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (ext_reset_in),
    .dout    (ext_rst_s)
  );

  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  assign clock_select_field = timer_control_q[`EBT_CKS_MSB:`EBT_CKS_LSB];
  assign ext_edge_sel       = timer_control_q[`EBT_EDG_MSB:`EBT_EDG_LSB];
  assign clr_sel            = timer_control_q[`EBT_CLR_MSB:`EBT_CLR_LSB];
  assign output_select_bits = timer_control_q[`EBT_OS_MSB:`EBT_OS_LSB];

  // level of a clock select setting; stopped reads low
  function src_level;
    input [2:0]  sel;
    input [11:0] tp;
    input        ext;
    begin
      case (sel)
        3'd1:    src_level = tp[0];
        3'd2:    src_level = tp[2];
        3'd3:    src_level = tp[4];
        3'd4:    src_level = tp[6];
        3'd5:    src_level = tp[11];
        3'd6:    src_level = ext;
        3'd7:    src_level = ext;
        default: src_level = 1'b0;
      endcase
    end
  endfunction

  // output action of one select pair on a match
  function apply_os;
    input [1:0] os;
    input       cur;
    begin
      case (os)
        `EBT_OS_ZERO: apply_os = 1'b0;
        `EBT_OS_ONE:  apply_os = 1'b1;
        `EBT_OS_INV:  apply_os = ~cur;
        default:      apply_os = cur;
      endcase
    end
  endfunction

  // rank of an output action: toggle > one > zero > keep
  function [1:0] os_rank;
    input [1:0] os;
    begin
      case (os)
        `EBT_OS_INV:  os_rank = 2'd3;
        `EBT_OS_ONE:  os_rank = 2'd2;
        `EBT_OS_ZERO: os_rank = 2'd1;
        default:      os_rank = 2'd0;
      endcase
    end
  endfunction

  assign wr_ctrl  = wr_en && (paddr == `EBT_OFF_CTRL);
  assign wr_count = wr_en && (paddr == `EBT_OFF_COUNT);
  assign wr_cmpa  = wr_en && (paddr == `EBT_OFF_CMPA);
  assign wr_cmpb  = wr_en && (paddr == `EBT_OFF_CMPB);

  // source level seen from the current select field; a rewrite of the field
  // is compared against the old source level, so a high-to-low swap between
  // sources (or to stopped) reads as a falling edge
  always @*
  begin
    src_lvl_d = src_level(clock_select_field, taps, ext_clk_s);
    case (ext_edge_sel)
      2'b00:   ext_edge = ext_prev_q & ~ext_clk_s;
      2'b01:   ext_edge = ~ext_prev_q & ext_clk_s;
      default: ext_edge = ext_prev_q ^ ext_clk_s;
    endcase
  end

  // internal taps: falling edge of selected source, including switch edges;
  // the external pin counts its chosen edges, the level test only on a swap
  assign sel_chg   = (clock_select_field != sel_prev_q);
  assign inc_pulse = (clock_select_field[2:1] == 2'b11) ?
                     (ext_edge | (sel_chg & src_lvl_q & ~src_lvl_d)) :
                     (src_lvl_q & ~src_lvl_d);

  // match is flagged in the cycle that advances the counter off the value
  assign match_a = inc_pulse && (count_value_q == compare_const_a_q) && !wr_cmpa;
  assign match_b = inc_pulse && (count_value_q == compare_const_b_q) && !wr_cmpb;

  assign clear_ev = ((clr_sel == `EBT_CLR_A) && match_a) ||
                    ((clr_sel == `EBT_CLR_B) && match_b) ||
                    ((clr_sel == `EBT_CLR_EXT) && ext_rst_s && !rst_prev_q);

  assign wrap_ev = inc_pulse && !clear_ev && !wr_count &&
                   (count_value_q == 8'hff);

  assign events = {match_b, match_a, wrap_ev};

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_lvl_q  <= 1'b0;
      ext_prev_q <= 1'b0;
      rst_prev_q <= 1'b0;
      sel_prev_q <= 3'b000;
    end
    else
    begin
      src_lvl_q  <= src_lvl_d;
      ext_prev_q <= ext_clk_s;
      rst_prev_q <= ext_rst_s;
      sel_prev_q <= clock_select_field;
    end
  end

  // counter: clear over write over increment
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_value_q <= `EBT_CNT_RST;
    else if (clear_ev)
      count_value_q <= 8'h00;
    else if (wr_count)
      count_value_q <= pwdata[7:0];
    else if (inc_pulse)
      count_value_q <= count_value_q + 8'h01;
  end

  // output pin: higher ranked action wins on simultaneous matches
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_q <= 1'b0;
    else if (match_a && match_b)
    begin
      if (os_rank(output_select_bits[1:0]) >= os_rank(output_select_bits[3:2]))
        out_q <= apply_os(output_select_bits[1:0], out_q);
      else
        out_q <= apply_os(output_select_bits[3:2], out_q);
    end
    else if (match_a)
      out_q <= apply_os(output_select_bits[1:0], out_q);
    else if (match_b)
      out_q <= apply_os(output_select_bits[3:2], out_q);
  end

  assign timer_output_pin = out_q;

  // registers; a status bit set by an event wins over a write-one clear
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_control_q    <= `EBT_CTRL_RST;
      compare_const_a_q  <= `EBT_CMP_RST;
      compare_const_b_q  <= `EBT_CMP_RST;
      timer_ctl_status_q <= 3'b000;
      irq_mask_q         <= 3'b000;
    end
    else
    begin
      if (wr_ctrl)
        timer_control_q <= pwdata[11:0];
      if (wr_cmpa)
        compare_const_a_q <= pwdata[7:0];
      if (wr_cmpb)
        compare_const_b_q <= pwdata[7:0];
      if (wr_en && (paddr == `EBT_OFF_IMASK))
        irq_mask_q <= pwdata[2:0];
      if (wr_en && (paddr == `EBT_OFF_STAT))
        timer_ctl_status_q <= (timer_ctl_status_q & ~pwdata[2:0]) | events;
      else
        timer_ctl_status_q <= timer_ctl_status_q | events;
    end
  end

  assign irq = |(timer_ctl_status_q & irq_mask_q);

  // read data registered from the setup phase, for the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == `EBT_OFF_CTRL)
        prdata <= {20'h00000, timer_control_q};
      else if (paddr == `EBT_OFF_STAT)
        prdata <= {29'h00000000, timer_ctl_status_q};
      else if (paddr == `EBT_OFF_COUNT)
        prdata <= {24'h000000, count_value_q};
      else if (paddr == `EBT_OFF_CMPA)
        prdata <= {24'h000000, compare_const_a_q};
      else if (paddr == `EBT_OFF_CMPB)
        prdata <= {24'h000000, compare_const_b_q};
      else if (paddr == `EBT_OFF_IMASK)
        prdata <= {29'h00000000, irq_mask_q};
      else
        prdata <= 32'h00000000;
    end
  end
endmodule // ebt_timer

// *** ebt_properties.sv ***
// Purpose: port-level checks for the eight-bit compare timer
// Assumes: register map of ebt_defs.vh, zero-wait apb
// Notes:   shadows control and compare writes
`timescale 1ns/1ps
`include "ebt_defs.vh"
module ebt_properties
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        external_count_input,
  input wire        ext_reset_in,
  input wire        timer_output_pin,
  input wire        irq
);
  reg  [11:0] ctrl_q;
  reg  [7:0]  cmpa_q;
  reg  [7:0]  cmpb_q;
  reg  [2:0]  quiet_q;
  wire        wr_en = psel && penable && pwrite;
  wire        rd_en = psel && penable && !pwrite;
  wire        ctl_wr = wr_en && paddr == `EBT_OFF_CTRL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last control write, saturating
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q  <= `EBT_CTRL_RST;
      cmpa_q  <= `EBT_CMP_RST;
      cmpb_q  <= `EBT_CMP_RST;
      quiet_q <= 3'h0;
    end
    else
    begin
      if (ctl_wr)
        ctrl_q <= pwdata[11:0];
      if (wr_en && paddr == `EBT_OFF_CMPA)
        cmpa_q <= pwdata[7:0];
      if (wr_en && paddr == `EBT_OFF_CMPB)
        cmpb_q <= pwdata[7:0];
      quiet_q <= ctl_wr ? 3'h0 : (quiet_q == 3'h6 ? quiet_q : quiet_q + 3'h1);
    end
  end
  pin_reset_a: assert property (!$past(presetn) |-> !timer_output_pin)
    else $error("pin not low after reset");
  stop_hold_a: assert property (quiet_q == 3'h6 && ctrl_q[2:0] == 3'h0
    |-> $stable(timer_output_pin)) else $error("pin moved while stopped");
  os_keep_a: assert property (quiet_q == 3'h6 && ctrl_q[11:8] == 4'h0
    |-> $stable(timer_output_pin)) else $error("pin moved with keep select");
  irq_fall_a: assert property ($fell(irq)
    |-> $past(wr_en && (paddr == `EBT_OFF_STAT || paddr == `EBT_OFF_IMASK)))
    else $error("irq fell without a clear");
  ctrl_read_a: assert property (rd_en && paddr == `EBT_OFF_CTRL |->
    {prdata[31:8], prdata[6:0]} == {20'h0, ctrl_q[11:8], ctrl_q[6:0]})
    else $error("control readback");
  cmp_read_a: assert property (rd_en && (paddr == `EBT_OFF_CMPA || paddr == `EBT_OFF_CMPB)
    |-> prdata == {24'h0, paddr == `EBT_OFF_CMPA ? cmpa_q : cmpb_q})
    else $error("compare readback");
  count_read_a: assert property (rd_en && paddr == `EBT_OFF_COUNT
    |-> prdata[31:8] == 24'h0) else $error("count wider than eight bits");
  stat_read_a: assert property (rd_en && paddr == `EBT_OFF_STAT
    |-> prdata[31:3] == 29'h0) else $error("status upper bits set");
endmodule // ebt_properties
bind ebt_timer ebt_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .external_count_input(external_count_input),
  .ext_reset_in(ext_reset_in), .timer_output_pin(timer_output_pin), .irq(irq));

// *** tb.sv ***
// Purpose: self-checking bench for the eight-bit compare timer
// Assumes: zero-wait apb slave, /2 tap on clock select 1
// Notes:   pulse-train compare constants drawn from a fixed seed
`timescale 1ns/1ps
`include "ebt_defs.vh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t: %h vs %h", $time, a, e); end end
module tb;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg         ext_cnt = 1'b0;
  reg         ext_rst = 1'b0;
  reg  [31:0] rd;
  reg         p;
  reg  [11:0] cyc;
  wire [31:0] prdata;
  wire        pready, pslverr, pin, irq;
  integer     fails = 0, n_compared = 0, seed = 32'h2e3d, i, n, ta, tl, a, b;
  always #2 pclk = ~pclk;
  // mirror of the free-running divider, to time source swaps
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cyc <= 12'h000;
    else
      cyc <= cyc + 12'h001;
  end
  ebt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_input(ext_cnt), .ext_reset_in(ext_rst),
    .timer_output_pin(pin), .irq(irq));
  task bus(input w, input [11:0] ad, input [31:0] d);
  begin
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    `CHK(pslverr, 1'b0)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask
  // wait for pin (s=0) or irq (s=1) to reach v, counting cycles
  task wt(input s, input v, output integer c);
  begin
    c = 0;
    while ((s ? irq : pin) !== v && c < 3000)
    begin
      @(negedge pclk);
      c++;
    end
    `CHK((s ? irq : pin), v)
    @(posedge pclk);
  end
  endtask
  function exp_pin(input [3:0] os, input q);
    if (os[1:0] == 2'b11 || os[3:2] == 2'b11) exp_pin = !q;
    else if (os[1:0] == 2'b10 || os[3:2] == 2'b10) exp_pin = 1'b1;
    else if (os[1:0] == 2'b01 || os[3:2] == 2'b01) exp_pin = 1'b0;
    else exp_pin = q;
  endfunction
  task end_sim;
  begin
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  initial
  begin
    #200000;
    fails++;
    end_sim;
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(pin, 1'b0)
    for (i = 0; i < 7; i++)
    begin
      bus(0, 12'(i * 4), 0);
      `CHK(rd, (i == 3 || i == 4) ? 32'hff : 32'h0)
    end
    // pulse train: A sets and clears the count, B ends the pulse
    a = 16 + ($random(seed) & 15);
    b = 2 + ($random(seed) & 7);
    bus(1, `EBT_OFF_CMPA, a);
    bus(1, `EBT_OFF_CMPB, b);
    bus(0, `EBT_OFF_CMPA, 0);
    `CHK(rd, a)
    bus(1, `EBT_OFF_CTRL, 32'h621);
    wt(0, 1, n);
    wt(0, 0, n);
    wt(0, 1, n);
    wt(0, 0, ta);
    wt(0, 1, tl);
    `CHK(ta, (b + 1) * 2)
    `CHK(ta + tl, (a + 1) * 2)
    // equal constants: every output-select code once
    bus(1, `EBT_OFF_CTRL, 0);
    bus(1, `EBT_OFF_CMPA, 3);
    bus(1, `EBT_OFF_CMPB, 3);
    bus(1, `EBT_OFF_IMASK, 2);
    for (i = 0; i < 16; i++)
    begin
      bus(1, `EBT_OFF_STAT, 7);
      bus(1, `EBT_OFF_COUNT, 2);
      p = pin;
      bus(1, `EBT_OFF_CTRL, (i << 8) | 1);
      wt(1, 1, n);
      bus(1, `EBT_OFF_CTRL, i << 8);
      `CHK(pin, exp_pin(i[3:0], p))
      bus(0, `EBT_OFF_STAT, 0);
      `CHK(rd[2:1], 2'b11)
    end
    // wrap flag raises the interrupt, write-one clears it
    bus(1, `EBT_OFF_STAT, 7);
    bus(1, `EBT_OFF_IMASK, 1);
    bus(1, `EBT_OFF_COUNT, 32'hfd);
    bus(1, `EBT_OFF_CTRL, 1);
    wt(1, 1, n);
    bus(1, `EBT_OFF_CTRL, 0);
    bus(0, `EBT_OFF_COUNT, 0);
    `CHK(rd[7:3], 5'h0)
    bus(1, `EBT_OFF_STAT, 1);
    `CHK(irq, 1'b0)
    // external reset clears a stopped counter
    bus(1, `EBT_OFF_CTRL, 32'h60);
    bus(1, `EBT_OFF_COUNT, 32'h55);
    ext_rst <= 1'b1;
    repeat (6) @(posedge pclk);
    bus(0, `EBT_OFF_COUNT, 0);
    `CHK(rd, 32'h0)
    // external count input: falling, rising, then both edges
    ext_rst <= 1'b0;
    for (i = 0; i < 3; i++)
    begin
      bus(1, `EBT_OFF_CTRL, 6 | (i << 3));
      bus(1, `EBT_OFF_COUNT, 0);
      repeat (5)
      begin
        ext_cnt <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_cnt <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      bus(1, `EBT_OFF_CTRL, 0);
      bus(0, `EBT_OFF_COUNT, 0);
      `CHK(rd, (i == 2) ? 32'ha : 32'h5)
    end
    // contention: write lands on the edge that the pin's fall increments
    ext_cnt <= 1'b1;
    bus(1, `EBT_OFF_CTRL, 32'h26);
    bus(1, `EBT_OFF_CMPA, 32'h10);
    bus(1, `EBT_OFF_CMPB, 32'h30);
    bus(1, `EBT_OFF_COUNT, 32'h10);
    bus(1, `EBT_OFF_STAT, 7);
    ext_cnt <= 1'b0;
    @(posedge pclk);
    bus(1, `EBT_OFF_COUNT, 32'h77);
    bus(0, `EBT_OFF_COUNT, 0);
    `CHK(rd, 32'h0)
    ext_cnt <= 1'b1;
    bus(1, `EBT_OFF_CMPB, 32'h20);
    bus(1, `EBT_OFF_COUNT, 32'h20);
    ext_cnt <= 1'b0;
    @(posedge pclk);
    bus(1, `EBT_OFF_CMPB, 32'h21);
    bus(0, `EBT_OFF_STAT, 0);
    `CHK(rd[2], 1'b0)
    bus(0, `EBT_OFF_CMPB, 0);
    `CHK(rd, 32'h21)
    ext_cnt <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_cnt <= 1'b0;
    @(posedge pclk);
    bus(1, `EBT_OFF_COUNT, 32'h40);
    bus(0, `EBT_OFF_COUNT, 0);
    `CHK(rd, 32'h40)
    // source swaps from a high level to a low one count once
    ext_cnt <= 1'b1;
    bus(1, `EBT_OFF_CTRL, 32'h6);
    bus(1, `EBT_OFF_COUNT, 0);
    bus(1, `EBT_OFF_CTRL, 0);
    bus(0, `EBT_OFF_COUNT, 0);
    `CHK(rd, 32'h1)
    ext_cnt <= 1'b0;
    bus(1, `EBT_OFF_COUNT, 0);
    // start of the slowest tap's high half, while the /128 tap is low
    while (cyc[11:3] != 9'h100) @(posedge pclk);
    bus(1, `EBT_OFF_CTRL, 32'h5);
    bus(1, `EBT_OFF_CTRL, 32'h6);
    bus(0, `EBT_OFF_COUNT, 0);
    `CHK(rd, 32'h1)
    bus(1, `EBT_OFF_CTRL, 32'h5);
    bus(1, `EBT_OFF_CTRL, 32'h4);
    bus(1, `EBT_OFF_CTRL, 0);
    bus(0, `EBT_OFF_COUNT, 0);
    `CHK(rd, 32'h2)
    end_sim;
  end
endmodule // tb
